/* File: rtl/doc_output_conditioner.sv */
// digital output conditioner: delay, hold, polarity and fallback per output
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: on-event waits activation delay, ms steps
// RULE2: off-event waits holding time, ms steps
// RULE3: selectable per-output polarity, positive default
// RULE4: safety assignments force zero delay, hold
// RULE5: safety assignments force positive polarity
// RULE6: pulse-train assignment takes embedded pin
// RULE7: assignment forces fallback enable off
// RULE8: fallback only for fieldbus-driven outputs
// RULE9: fallback off keeps output on fault
// RULE10: command-bit assignment not disabled by fault
// RULE11: extension outputs only with module present
// RULE12: fallback on forces inactive on error
// RULE13: unassigned output follows command, holds on error
// RULE14: timers count ms tick, reversal cancels
module doc_output_conditioner #(
  parameter int unsigned TICK_CYCLES = doc_pkg::TICK_CYCLES
) (
  input  wire logic                                      clk,
  input  wire logic                                      rst_n,
  // register port
  input  wire logic [7:0]                                reg_addr,
  input  wire logic [31:0]                               reg_wdata,
  input  wire logic                                      reg_wr,
  input  wire logic                                      reg_rd,
  output logic      [31:0]                               reg_rdata,
  // drive-side sources
  input  wire logic [doc_pkg::NUM_OUT-1:0]               event_in,
  input  wire logic [doc_pkg::NUM_OUT-1:0]               cmd_bit,
  input  wire logic                                      fault_state,
  input  wire logic                                      comm_error,
  input  wire logic                                      ext_module_present,
  input  wire logic                                      pulse_train_assigned,
  input  wire logic                                      pulse_train_level,
  // pins
  output logic                                           embedded_output,
  output logic                                           extension_output_a,
  output logic                                           extension_output_b
);
  // register map in byte addresses; each output owns a block of four words:
  //   base+0x0 assignment code, base+0x4 activation delay in ms,
  //   base+0x8 holding time in ms, base+0xC bit0 polarity, bit1 fallback
  //   0x30 status: pins [2:0], internal on state [5:3], extension fitted [6]
  //   reads return effective values, so forced settings show as forced
  localparam logic [7:0] OFS_ASSIGN   = 8'h00;
  localparam logic [7:0] OFS_DELAY    = 8'h04;
  localparam logic [7:0] OFS_HOLD     = 8'h08;
  localparam logic [7:0] OFS_CTRL     = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h30;
  localparam logic [7:0] BLOCK_STRIDE = 8'h10;
  localparam logic [15:0] TICK_LAST   = 16'(TICK_CYCLES - 1);
  localparam logic [15:0] DELAY_MAX   = 16'(doc_pkg::ACT_DELAY_MAX_MS);
  localparam logic [15:0] HOLD_MAX    = 16'(doc_pkg::HOLD_TIME_MAX_MS);

  // status inputs from outside the clock domain: two stages
  logic [doc_pkg::NUM_OUT-1:0] ev_s1_q, ev_s2_q, cmd_s1_q, cmd_s2_q;
  logic [4:0]                  misc_s1_q, misc_s2_q;

  // event synchroniser; only the second stage feeds the timers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_s1_q <= '0;
      ev_s2_q <= '0;
    end else begin
      ev_s1_q <= event_in;
      ev_s2_q <= ev_s1_q;
    end
  end

  // fieldbus command bit synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_s1_q <= '0;
      cmd_s2_q <= '0;
    end else begin
      cmd_s1_q <= cmd_bit;
      cmd_s2_q <= cmd_s1_q;
    end
  end

  // drive state and pulse-train synchroniser; same stage count as the data
  // so a fault and a command change seen together stay together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      misc_s1_q <= '0;
      misc_s2_q <= '0;
    end else begin
      misc_s1_q <= {fault_state, comm_error, ext_module_present, pulse_train_assigned, pulse_train_level};
      misc_s2_q <= misc_s1_q;
    end
  end
  logic fault_s, comm_err_s, ext_present_s, pto_assigned_s, pto_level_s;
  assign {fault_s, comm_err_s, ext_present_s, pto_assigned_s, pto_level_s} = misc_s2_q;

  // millisecond tick divider; one shared enable keeps all outputs aligned
  logic [15:0] div_q;
  logic        tick_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == TICK_LAST) begin // RULE14
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // per-output configuration and timing state
  logic [3:0]  assign_q [doc_pkg::NUM_OUT];
  logic [15:0] delay_q  [doc_pkg::NUM_OUT];
  logic [15:0] hold_q   [doc_pkg::NUM_OUT];
  logic        pol_q    [doc_pkg::NUM_OUT];
  logic        fb_en_q  [doc_pkg::NUM_OUT];
  logic [doc_pkg::NUM_OUT-1:0] pin_q;
  logic [doc_pkg::NUM_OUT-1:0] logic_on;
  logic [doc_pkg::NUM_OUT-1:0] present;

  assign present = {ext_present_s, ext_present_s, 1'b1}; // RULE11

  genvar g;
  generate
    for (g = 0; g < doc_pkg::NUM_OUT; g++) begin : g_out
      localparam logic [7:0] BASE = 8'(g * 16);
      logic       safety;
      logic       assigned;
      logic       is_cmd;
      logic       fb_eff;
      logic       pol_eff;
      logic [15:0] dly_eff;
      logic [15:0] hld_eff;
      logic       src;
      logic       wr_asg;
      logic       wr_dly;
      logic       wr_hld;
      logic       wr_ctrl;
      logic [15:0] cnt_q;
      logic       hold_err_q;
      doc_pkg::doc_state_e st_q;

      assign safety = (assign_q[g] == doc_pkg::FAULT_STATE_ASSIGN) ||
                      (assign_q[g] == doc_pkg::MAINS_CONTACTOR_ASSIGN) ||
                      (assign_q[g] == doc_pkg::DC_CHARGING_ASSIGN) ||
                      (assign_q[g] == doc_pkg::BRAKE_SEQUENCE_ASSIGN) ||
                      (assign_q[g] == doc_pkg::OUTPUT_CONTACTOR_ASSIGN);
      // embedded output counts as assigned when the pulse train owns it
      assign assigned = (assign_q[g] != doc_pkg::ASSIGN_NONE) ||
                        ((g == doc_pkg::IDX_EMBEDDED) && pto_assigned_s);
      assign is_cmd   = (assign_q[g] == doc_pkg::ASSIGN_CMD_BIT);
      assign fb_eff   = fb_en_q[g] && !assigned; // RULE7
      assign pol_eff  = safety ? doc_pkg::POL_POSITIVE : pol_q[g]; // RULE5
      assign dly_eff  = safety ? 16'h0000 : delay_q[g]; // RULE4
      assign hld_eff  = safety ? 16'h0000 : hold_q[g]; // RULE4

      // source select: fieldbus bit when unassigned or command-bit assigned
      always_comb begin
        if (!assigned || is_cmd) begin
          src = cmd_s2_q[g]; // RULE8 RULE13
        end else begin
          src = ev_s2_q[g];
        end
      end

      // write strobes for this output's four words
      assign wr_asg  = reg_wr && (reg_addr == BASE + OFS_ASSIGN);
      assign wr_dly  = reg_wr && (reg_addr == BASE + OFS_DELAY);
      assign wr_hld  = reg_wr && (reg_addr == BASE + OFS_HOLD);
      assign wr_ctrl = reg_wr && (reg_addr == BASE + OFS_CTRL);

      // assignment code; decides source, safety forcing and fallback
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          assign_q[g] <= doc_pkg::ASSIGN_NONE;
        end else if (wr_asg) begin
          assign_q[g] <= reg_wdata[3:0];
        end
      end

      // activation delay, clamped; refused while a safety function owns the pin
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          delay_q[g] <= 16'(doc_pkg::ACT_DELAY_RST_MS);
        end else if (wr_dly && !safety) begin // RULE4
          delay_q[g] <= (reg_wdata[15:0] > DELAY_MAX) ? DELAY_MAX : reg_wdata[15:0]; // RULE1
        end
      end

      // holding time, clamped at HOLD_MAX rather than DELAY_MAX; same refusal as the delay
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          hold_q[g] <= 16'(doc_pkg::HOLD_TIME_RST_MS);
        end else if (wr_hld && !safety) begin // RULE4
          hold_q[g] <= (reg_wdata[15:0] > HOLD_MAX) ? HOLD_MAX : reg_wdata[15:0]; // RULE2
        end
      end

      // polarity and fallback kept as written; forcing applies only on use,
      // so a setting comes back once the forcing assignment is removed
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pol_q[g]   <= doc_pkg::POL_RST;
          fb_en_q[g] <= doc_pkg::FALLBACK_RST;
        end else if (wr_ctrl) begin
          pol_q[g]   <= reg_wdata[0]; // RULE3
          fb_en_q[g] <= reg_wdata[1];
        end
      end

      // delay and hold timer; a reversal before expiry cancels the change
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          st_q  <= doc_pkg::DOC_IDLE_OFF;
          cnt_q <= '0;
        end else begin
          case (st_q)
            doc_pkg::DOC_IDLE_OFF: begin
              if (src) begin
                cnt_q <= '0;
                st_q  <= (dly_eff == 16'h0000) ? doc_pkg::DOC_IDLE_ON : doc_pkg::DOC_WAIT_ON; // RULE1
              end
            end
            doc_pkg::DOC_WAIT_ON: begin
              if (!src) begin
                st_q <= doc_pkg::DOC_IDLE_OFF; // RULE14
              end else if (tick_q) begin
                if (cnt_q + 16'h0001 >= dly_eff) begin
                  st_q <= doc_pkg::DOC_IDLE_ON; // RULE1
                end
                cnt_q <= cnt_q + 16'h0001;
              end
            end
            doc_pkg::DOC_IDLE_ON: begin
              if (!src) begin
                cnt_q <= '0;
                st_q  <= (hld_eff == 16'h0000) ? doc_pkg::DOC_IDLE_OFF : doc_pkg::DOC_WAIT_OFF; // RULE2
              end
            end
            doc_pkg::DOC_WAIT_OFF: begin
              if (src) begin
                st_q <= doc_pkg::DOC_IDLE_ON; // RULE14
              end else if (tick_q) begin
                if (cnt_q + 16'h0001 >= hld_eff) begin
                  st_q <= doc_pkg::DOC_IDLE_OFF; // RULE2
                end
                cnt_q <= cnt_q + 16'h0001;
              end
            end
            default: st_q <= doc_pkg::DOC_IDLE_OFF;
          endcase
        end
      end

      assign logic_on[g] = (st_q == doc_pkg::DOC_IDLE_ON) || (st_q == doc_pkg::DOC_WAIT_OFF);

      // freeze marker: on an error without fallback the fieldbus output holds
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          hold_err_q <= 1'b0;
        end else begin
          hold_err_q <= (fault_s || comm_err_s) && !fb_eff && (!assigned || is_cmd); // RULE9 RULE10 RULE13
        end
      end

      // pin level: polarity, fallback, pulse-train takeover, presence
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_q[g] <= 1'b0;
        end else if (!present[g]) begin
          pin_q[g] <= 1'b0; // RULE11
        end else if ((g == doc_pkg::IDX_EMBEDDED) && pto_assigned_s) begin
          pin_q[g] <= pto_level_s; // RULE6
        end else if (fb_eff && !assigned && (fault_s || comm_err_s)) begin
          pin_q[g] <= pol_eff; // RULE12 inactive level is the inverse of active
        end else if (hold_err_q) begin
          pin_q[g] <= pin_q[g]; // RULE9 RULE13
        end else begin
          pin_q[g] <= logic_on[g] ^ pol_eff; // RULE3
        end
      end
    end
  endgenerate

  assign embedded_output    = pin_q[doc_pkg::IDX_EMBEDDED];
  assign extension_output_a = pin_q[doc_pkg::IDX_EXT_A];
  assign extension_output_b = pin_q[doc_pkg::IDX_EXT_B];

  // read port: data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        for (int i = 0; i < doc_pkg::NUM_OUT; i++) begin
          if (reg_addr == 8'(i * 16) + OFS_ASSIGN) begin
            reg_rdata <= {28'h0, assign_q[i]};
          end
          if (reg_addr == 8'(i * 16) + OFS_DELAY) begin
            reg_rdata <= {16'h0, g_out_dly(i)};
          end
          if (reg_addr == 8'(i * 16) + OFS_HOLD) begin
            reg_rdata <= {16'h0, g_out_hld(i)};
          end
          if (reg_addr == 8'(i * 16) + OFS_CTRL) begin
            reg_rdata <= {30'h0, g_out_fb(i), g_out_pol(i)};
          end
        end
        if (reg_addr == OFS_STATUS) begin
          reg_rdata <= {24'h0, 1'b0, ext_present_s, logic_on, pin_q};
        end
      end
    end
  end

  // effective values shown to software
  function automatic logic [15:0] g_out_dly(input int i);
    case (i)
      0:       g_out_dly = g_out[0].dly_eff;
      1:       g_out_dly = g_out[1].dly_eff;
      default: g_out_dly = g_out[2].dly_eff;
    endcase
  endfunction
  function automatic logic [15:0] g_out_hld(input int i);
    case (i)
      0:       g_out_hld = g_out[0].hld_eff;
      1:       g_out_hld = g_out[1].hld_eff;
      default: g_out_hld = g_out[2].hld_eff;
    endcase
  endfunction
  function automatic logic g_out_fb(input int i);
    case (i)
      0:       g_out_fb = g_out[0].fb_eff;
      1:       g_out_fb = g_out[1].fb_eff;
      default: g_out_fb = g_out[2].fb_eff;
    endcase
  endfunction
  function automatic logic g_out_pol(input int i);
    case (i)
      0:       g_out_pol = g_out[0].pol_eff;
      1:       g_out_pol = g_out[1].pol_eff;
      default: g_out_pol = g_out[2].pol_eff;
    endcase
  endfunction
endmodule
`default_nettype wire

/* File: rtl/doc_pkg.sv */
// constants and types shared by the digital output conditioner
package doc_pkg;
  // clock and tick timing
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned TICK_PERIOD_US    = 1000;
  localparam int unsigned TICK_CYCLES       = (CLK_HZ / 1_000_000) * TICK_PERIOD_US;
  // delay limits in milliseconds
  localparam int unsigned ACT_DELAY_MAX_MS  = 60000;
  localparam int unsigned HOLD_TIME_MAX_MS  = 9999;
  localparam int unsigned ACT_DELAY_RST_MS  = 0;
  localparam int unsigned HOLD_TIME_RST_MS  = 0;
  localparam int unsigned DELAY_W           = 16;
  // output count and indexes
  localparam int unsigned NUM_OUT           = 3;
  localparam int unsigned IDX_EMBEDDED      = 0;
  localparam int unsigned IDX_EXT_A         = 1;
  localparam int unsigned IDX_EXT_B         = 2;
  // assignment codes
  localparam int unsigned ASSIGN_W                 = 4;
  localparam logic [3:0] ASSIGN_NONE               = 4'h0;
  localparam logic [3:0] ASSIGN_EVENT              = 4'h1;
  localparam logic [3:0] ASSIGN_CMD_BIT            = 4'h2;
  localparam logic [3:0] FAULT_STATE_ASSIGN        = 4'h3;
  localparam logic [3:0] MAINS_CONTACTOR_ASSIGN    = 4'h4;
  localparam logic [3:0] DC_CHARGING_ASSIGN        = 4'h5;
  localparam logic [3:0] BRAKE_SEQUENCE_ASSIGN     = 4'h6;
  localparam logic [3:0] OUTPUT_CONTACTOR_ASSIGN   = 4'h7;
  // polarity encoding and reset value
  localparam logic POL_POSITIVE = 1'b0;
  localparam logic POL_NEGATIVE = 1'b1;
  localparam logic POL_RST      = POL_POSITIVE;
  localparam logic FALLBACK_RST = 1'b0;
  // per-output timer state
  typedef enum logic [3:0] {
    DOC_IDLE_OFF = 4'b0001,
    DOC_WAIT_ON  = 4'b0010,
    DOC_IDLE_ON  = 4'b0100,
    DOC_WAIT_OFF = 4'b1000
  } doc_state_e;
endpackage

/* File: testbench/doc_output_sva.sv */
// port checker for the digital output conditioner
`timescale 1ns/1ps
`default_nettype none
module doc_output_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        ext_module_present,
  input wire logic        pulse_train_assigned,
  input wire logic        pulse_train_level,
  input wire logic        embedded_output,
  input wire logic        extension_output_a,
  input wire logic        extension_output_b
);
  logic [3:0] asg2_q;
  // shadow of output 2 assignment; only legal codes are ever written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) asg2_q <= 4'h0;
    else if (reg_wr && reg_addr == 8'h20) asg2_q <= reg_wdata[3:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");
  property p_unmapped; $past(reg_rd) && $past(reg_addr) > 8'h30 |-> reg_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_pins;
    $past(reg_rd) && $past(reg_addr) == 8'h30 |-> reg_rdata[0] == $past(embedded_output)
      && reg_rdata[1] == $past(extension_output_a) && reg_rdata[2] == $past(extension_output_b);
  endproperty
  a_status_pins: assert property (p_status_pins) else $error("status pins mismatch");
  property p_ext_absent; !ext_module_present [*6] |-> !extension_output_a && !extension_output_b; endproperty
  a_ext_absent: assert property (p_ext_absent) else $error("extension pin active without module");
  property p_pto_high; (pulse_train_assigned && pulse_train_level) [*8] |-> embedded_output; endproperty
  a_pto_high: assert property (p_pto_high) else $error("embedded pin not high for pulse train");
  property p_pto_low; (pulse_train_assigned && !pulse_train_level) [*8] |-> !embedded_output; endproperty
  a_pto_low: assert property (p_pto_low) else $error("embedded pin not low for pulse train");
  property p_safe_delay; $past(reg_rd) && $past(reg_addr) == 8'h24 && $past(asg2_q) inside {[4'h3:4'h7]}
    |-> reg_rdata == 32'h0;
  endproperty
  a_safe_delay: assert property (p_safe_delay) else $error("safety delay not zero");
  property p_safe_pol; $past(reg_rd) && $past(reg_addr) == 8'h2C && $past(asg2_q) inside {[4'h3:4'h7]}
    |-> !reg_rdata[0];
  endproperty
  a_safe_pol: assert property (p_safe_pol) else $error("safety polarity not positive");
  property p_fb_off; $past(reg_rd) && $past(reg_addr) == 8'h2C && $past(asg2_q) != 4'h0 |-> !reg_rdata[1];
  endproperty
  a_fb_off: assert property (p_fb_off) else $error("fallback not forced off");
endmodule
bind doc_output_conditioner doc_output_sva u_sva (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .ext_module_present, .pulse_train_assigned, .pulse_train_level, .embedded_output,
  .extension_output_a, .extension_output_b);
`default_nettype wire

/* File: testbench/doc_load_model.sv */
// load model: coil picks up once a pin holds for two cycles
`timescale 1ns/1ps
`default_nettype none
module doc_load_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] drive,
  output logic      [2:0] energized_q
);
  logic [2:0] seen_q;
  // two samples stand in for coil inertia, so glitches never pick up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 3'h0;
      energized_q <= 3'h0;
    end else begin
      seen_q <= drive;
      energized_q <= seen_q & drive;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb_digital_output_conditioner.sv */
// self-checking bench for the digital output conditioner
`timescale 1ns/1ps
`default_nettype none
module tb_digital_output_conditioner;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [2:0]  event_in = 3'h0;
  logic [2:0]  cmd_bit = 3'h0;
  logic        fault_state = 1'b0;
  logic        comm_error = 1'b0;
  logic        ext_module_present = 1'b1;
  logic        pulse_train_assigned = 1'b0;
  logic        pulse_train_level = 1'b0;
  logic        embedded_output, extension_output_a, extension_output_b;
  logic [2:0]  load_on;
  int          failures = 0;
  int          tests_run = 0;
  wire  [2:0]  pins = {extension_output_b, extension_output_a, embedded_output};
  // short tick keeps ms waits to a few cycles
  doc_output_conditioner #(.TICK_CYCLES(4)) DUT (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .event_in, .cmd_bit, .fault_state, .comm_error, .ext_module_present, .pulse_train_assigned,
    .pulse_train_level, .embedded_output, .extension_output_a, .extension_output_b);
  doc_load_model u_load (.clk, .rst_n, .drive(pins), .energized_q(load_on));
  always #12.5 clk = ~clk;
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic note(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (!ok) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data is valid only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    note((reg_rdata & m) === e, reg_rdata, e);
    @(posedge clk);
  endtask
  task automatic pin(input int i, input logic e);
    @(negedge clk);
    note(pins[i] === e, {31'h0, pins[i]}, {31'h0, e});
    @(posedge clk);
  endtask
  // hang guard
  initial begin
    cyc(20000);
    failures++;
    end_of_test();
  end
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    for (int n = 0; n < 3; n++)
      for (int k = 0; k < 4; k++) rd(8'(n * 16 + k * 4), 32'h0, 32'hFFFFFFFF);
    wr(8'h40, 32'h5A);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    wr(8'h14, 32'hFFFF);
    rd(8'h14, 32'hEA60, 32'hFFFF);
    wr(8'h18, 32'hFFFF);
    rd(8'h18, 32'h270F, 32'hFFFF);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0);
    // event on output 0 with 5 ms waits both ways
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h5);
    event_in <= 3'h1;
    cyc(10);
    pin(0, 1'b0);
    cyc(30);
    pin(0, 1'b1);
    event_in <= 3'h0;
    cyc(10);
    pin(0, 1'b1);
    cyc(30);
    pin(0, 1'b0);
    event_in <= 3'h1;
    cyc(8);
    event_in <= 3'h0;
    cyc(40);
    pin(0, 1'b0);
    wr(8'h0C, 32'h1);
    cyc(8);
    pin(0, 1'b1);
    event_in <= 3'h1;
    cyc(40);
    pin(0, 1'b0);
    event_in <= 3'h0;
    wr(8'h0C, 32'h0);
    cyc(40);
    for (int c = 3; c < 8; c++) begin
      wr(8'h20, 32'(c));
      wr(8'h24, 32'h64);
      wr(8'h28, 32'h64);
      wr(8'h2C, 32'h3);
      rd(8'h24, 32'h0, 32'hFFFF);
      rd(8'h28, 32'h0, 32'hFFFF);
      rd(8'h2C, 32'h0, 32'h3);
    end
    // unassigned output 1: freeze without fallback, drop with it
    cmd_bit <= 3'h2;
    cyc(8);
    pin(1, 1'b1);
    comm_error <= 1'b1;
    cyc(8);
    cmd_bit <= 3'h0;
    cyc(8);
    pin(1, 1'b1);
    comm_error <= 1'b0;
    cyc(8);
    pin(1, 1'b0);
    wr(8'h1C, 32'h2);
    rd(8'h1C, 32'h2, 32'h3);
    cmd_bit <= 3'h2;
    cyc(8);
    pin(1, 1'b1);
    fault_state <= 1'b1;
    cyc(8);
    pin(1, 1'b0);
    fault_state <= 1'b0;
    wr(8'h10, 32'h1);
    rd(8'h1C, 32'h0, 32'h2);
    wr(8'h20, 32'h2);
    rd(8'h2C, 32'h1, 32'h1);
    wr(8'h2C, 32'h0);
    cmd_bit <= 3'h4;
    cyc(8);
    pin(2, 1'b1);
    note(load_on[2] === 1'b1, {29'h0, load_on}, 32'h4);
    fault_state <= 1'b1;
    cmd_bit <= 3'h0;
    cyc(8);
    pin(2, 1'b1);
    fault_state <= 1'b0;
    cmd_bit <= 3'h4;
    ext_module_present <= 1'b0;
    cyc(8);
    pin(2, 1'b0);
    rd(8'h30, 32'h0, 32'h46);
    ext_module_present <= 1'b1;
    cyc(8);
    pin(2, 1'b1);
    // pulse train takes the embedded pin and kills its fallback
    wr(8'h00, 32'h0);
    wr(8'h0C, 32'h2);
    pulse_train_assigned <= 1'b1;
    pulse_train_level <= 1'b1;
    cyc(10);
    pin(0, 1'b1);
    rd(8'h0C, 32'h0, 32'h2);
    pulse_train_level <= 1'b0;
    cyc(10);
    pin(0, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
